/* File: tcs_pkg.sv */
package tcs_pkg;
  localparam logic [11:0] TCS_SETUP_OFFSET = 12'h000;
  localparam logic [11:0] TCS_STATUS_OFFSET = 12'h004;
  localparam int TCS_JOIN_BIT = 0;
  localparam int TCS_MODE_LSB = 1;
  localparam int TCS_MODE_MSB = 2;
  localparam int TCS_SEL_LSB = 3;
  localparam int TCS_SEL_MSB = 6;
  localparam int TCS_RLI_L_BIT = 7;
  localparam int TCS_RLI_H_BIT = 8;
  localparam int TCS_SYNC_LSB = 9;
  localparam int TCS_SYNC_MSB = 16;
  localparam int TCS_NUM_IN = 8;
  localparam logic [31:0] TCS_SETUP_RESET = 32'h0001FE00;
  localparam logic [31:0] TCS_SETUP_MASK = 32'h0001FFFF;
  localparam logic [1:0] TCS_MODE_BUS = 2'h0;
  localparam logic [1:0] TCS_MODE_PRESCALED = 2'h1;
  localparam logic [1:0] TCS_MODE_INPUT = 2'h2;
  localparam logic [1:0] TCS_MODE_RESERVED = 2'h3;
  localparam logic [3:0] TCS_SEL_MAX = 4'h7;
endpackage

/* File: tcs_sync.sv */
`timescale 1ns/1ps
module tcs_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  logic sync_ff;
  // Only the second stage is read, keeping metastability contained
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
  assign dout = sync_ff;
endmodule

/* File: tcs_setup.sv */
`timescale 1ns/1ps
module tcs_setup (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [tcs_pkg::TCS_NUM_IN-1:0] timer_in,
  input wire logic low_reload_req,
  input wire logic high_reload_req,
  output logic counter_join,
  output logic [1:0] clock_source_mode,
  output logic timer_tick,
  output logic prescale_tick,
  output logic [tcs_pkg::TCS_NUM_IN-1:0] event_in,
  output logic low_reload_en,
  output logic high_reload_en
);
  import tcs_pkg::*;

  logic [31:0] setup_ff;
  logic [31:0] nxt_setup;
  logic wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [TCS_NUM_IN-1:0] sync_in;
  logic clk_prev_ff;
  logic [3:0] sel_q_ff;

  wire addr_ph = hsel & hready & htrans[1];
  wire wr_ph = addr_ph & hwrite;
  wire rd_ph = addr_ph & ~hwrite;
  wire [11:0] a_off = {haddr[11:2], 2'b00};
  wire wr_setup = wr_pend_ff & (wr_addr_ff == TCS_SETUP_OFFSET);

  wire [3:0] edge_sel = setup_ff[TCS_SEL_MSB:TCS_SEL_LSB];
  wire [1:0] mode = setup_ff[TCS_MODE_MSB:TCS_MODE_LSB];
  wire [TCS_NUM_IN-1:0] sync_en = setup_ff[TCS_SYNC_MSB:TCS_SYNC_LSB];
  wire join_on = setup_ff[TCS_JOIN_BIT];
  wire rli_l = setup_ff[TCS_RLI_L_BIT];
  wire rli_h = setup_ff[TCS_RLI_H_BIT];

  // Reserved codes refused so mode and select stay on legal values
  wire [1:0] wr_mode = hwdata[TCS_MODE_MSB:TCS_MODE_LSB];
  wire [3:0] wr_sel = hwdata[TCS_SEL_MSB:TCS_SEL_LSB];
  wire [1:0] keep_mode = (wr_mode == TCS_MODE_RESERVED) ? mode : wr_mode;
  wire [3:0] keep_sel = (wr_sel > TCS_SEL_MAX) ? edge_sel : wr_sel;

  always_comb begin
    nxt_setup = setup_ff;
    if (wr_setup) begin
      // Inhibit bits take any time, no running check
      nxt_setup = hwdata & TCS_SETUP_MASK;
      nxt_setup[TCS_MODE_MSB:TCS_MODE_LSB] = keep_mode;
      nxt_setup[TCS_SEL_MSB:TCS_SEL_LSB] = keep_sel;
    end
  end

  // Clock candidate input: index is select code divided by two
  wire [1:0] clk_idx = edge_sel[2:1];
  wire clk_fall = edge_sel[0];

  genvar gi;
  generate
    for (gi = 0; gi < TCS_NUM_IN; gi++) begin : g_in
      logic s_out;
      tcs_sync u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .din(timer_in[gi]),
        .dout(s_out)
      );
      assign sync_in[gi] = s_out;
      // Clock input always synchronized in input mode; its enable unused
      wire force_sync = mode[1] & (gi < 4) & ({30'h0, clk_idx} == gi);
      assign event_in[gi] = (sync_en[gi] | force_sync) ? s_out
                                                       : timer_in[gi];
    end
  endgenerate

  // Sampled clock assumes pulses of at least one bus period
  wire clk_now = sync_in[clk_idx] ^ clk_fall;
  // Rising edge of the (optionally inverted) sample, single cycle
  wire clk_edge = clk_now & ~clk_prev_ff
                  & (sel_q_ff == edge_sel);

  always_comb begin
    case (mode)
      TCS_MODE_BUS: begin
        timer_tick = 1'b1;
        prescale_tick = 1'b1;
      end
      TCS_MODE_PRESCALED: begin
        timer_tick = 1'b1;
        prescale_tick = clk_edge;
      end
      TCS_MODE_INPUT: begin
        timer_tick = clk_edge;
        prescale_tick = clk_edge;
      end
      default: begin
        timer_tick = 1'b0;
        prescale_tick = 1'b0;
      end
    endcase
  end

  // Joined mode: high half follows the low inhibit, own bit ignored
  assign counter_join = join_on;
  assign clock_source_mode = mode;
  assign low_reload_en = low_reload_req & ~rli_l;
  assign high_reload_en = high_reload_req
                          & ~(join_on ? rli_l : rli_h);

  wire [31:0] status = {23'h0, timer_tick, prescale_tick, sync_in[3:0],
                        mode, join_on};

  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd_ph) begin
      if (a_off == TCS_SETUP_OFFSET) begin
        nxt_rdata = setup_ff;
      end else if (a_off == TCS_STATUS_OFFSET) begin
        nxt_rdata = status;
      end else begin
        nxt_rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      setup_ff <= TCS_SETUP_RESET;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      rdata_ff <= 32'h00000000;
      clk_prev_ff <= 1'b0;
      sel_q_ff <= 4'h0;
    end else begin
      setup_ff <= nxt_setup;
      wr_pend_ff <= wr_ph;
      wr_addr_ff <= a_off;
      rdata_ff <= nxt_rdata;
      clk_prev_ff <= clk_now;
      sel_q_ff <= edge_sel;
    end
  end

  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

/* File: tcs_setup_assertions.sv */
`timescale 1ns/1ps
module tcs_chk
  import tcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic low_reload_req,
  input wire logic high_reload_req,
  input wire logic counter_join,
  input wire logic [1:0] clock_source_mode,
  input wire logic timer_tick,
  input wire logic prescale_tick,
  input wire logic low_reload_en,
  input wire logic high_reload_en
);
  logic [1:0] md;
  assign md = clock_source_mode;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_edge; md != 2'h0 && prescale_tick; endsequence
  property p_m0; md == 2'h0 |-> timer_tick && prescale_tick; endproperty
  a_m0: assert property (p_m0) else $error("mode 0 tick");
  property p_m1; md == 2'h1 |-> timer_tick; endproperty
  a_m1: assert property (p_m1) else $error("mode 1 tick");
  property p_m2; md == 2'h2 |-> timer_tick == prescale_tick; endproperty
  a_m2: assert property (p_m2) else $error("mode 2 tick");
  property p_pulse; s_edge |=> !prescale_tick || md == 2'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_nores; md != 2'h3; endproperty
  a_nores: assert property (p_nores) else $error("mode 3");
  property p_lo; low_reload_en |-> low_reload_req; endproperty
  a_lo: assert property (p_lo) else $error("low reload");
  property p_hi; high_reload_en |-> high_reload_req; endproperty
  a_hi: assert property (p_hi) else $error("high reload");
  property p_join; counter_join && low_reload_req && high_reload_req
    |-> low_reload_en == high_reload_en; endproperty
  a_join: assert property (p_join) else $error("joined reload");
endmodule
bind tcs_setup tcs_chk tcs_chk_inst (.clk_sys, .sys_rst, .low_reload_req,
  .high_reload_req, .counter_join, .clock_source_mode, .timer_tick,
  .prescale_tick, .low_reload_en, .high_reload_en);

/* File: timer_counter_setup_logic_test.sv */
`timescale 1ns/1ps
`define CHK(n, v) cmp(n, v)
module timer_counter_setup_logic_test;
  import tcs_pkg::*;
  logic clk_sys = 0, sys_rst = 1, hsel = 0, hwrite = 0, rd_ph = 0;
  logic lreq = 0, hreq = 0, hreadyout, hresp, counter_join, timer_tick;
  logic prescale_tick, low_reload_en, high_reload_en;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d, e, base, pcnt = 0;
  logic [1:0] htrans = 0, snap = 0, clock_source_mode;
  logic [7:0] tin = 0, event_in;
  logic [31:0] exp_q[$];
  int fail_count = 0, samples_checked = 0, seed = 32'hA87EA8CD, r;
  always #4 clk_sys = ~clk_sys;
  tcs_setup tcs_setup_inst (.clk_sys, .sys_rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .timer_in(tin), .low_reload_req(lreq), .high_reload_req(hreq),
    .counter_join, .clock_source_mode, .timer_tick, .prescale_tick,
    .event_in, .low_reload_en, .high_reload_en);
  wire [31:0] outs = {27'h0, clock_source_mode, counter_join, low_reload_en,
    high_reload_en};
  task cmp(input string n, input logic [31:0] v);
    e = exp_q.pop_front();
    samples_checked++;
    if (e !== v) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task final_report;
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task bus(input logic w, input logic [31:0] a, v);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata, rd_ph} <= {1'b0, 2'h0, v, !w};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd_ph <= 0;
  endtask
  task rd(input logic [31:0] a, x);
    exp_q.push_back(x);
    bus(0, a, 32'h0);
  endtask
  always @(posedge clk_sys) begin
    if (prescale_tick) pcnt <= pcnt + 1;
    if (rd_ph) `CHK("hrdata", hrdata);
    if (snap == 2'h1) `CHK("outputs", outs);
    if (snap == 2'h2) `CHK("ticks", pcnt);
    if (snap == 2'h2) `CHK("events", {24'h0, event_in});
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
    rd(32'h0, TCS_SETUP_RESET);
    bus(1, 32'h4, 32'hFFFFFFFF);
    rd(32'h0, TCS_SETUP_RESET);
    rd(32'h8, 32'h0);
    repeat (12) begin
      d = $random(seed) & TCS_SETUP_MASK;
      d[6] = 0;
      if (d[2:1] == TCS_MODE_RESERVED) d[2] = 0;
      bus(1, 32'h0, d);
      rd(32'h0, d);
      r = $random(seed);
      {lreq, hreq, snap} <= {r[1:0], 2'h1};
      exp_q.push_back({27'h0, d[2:0], r[1] & !d[7],
        r[0] & !(d[0] ? d[7] : d[8])});
      @(posedge clk_sys);
      snap <= 0;
    end
    // Reserved mode and select codes must leave the old fields in place
    base = ($random(seed) & TCS_SETUP_MASK) | 32'h7E;
    bus(1, 32'h0, base);
    rd(32'h0, {base[31:7], d[6:1], base[0]});
    for (int m = 1; m < 3; m++) begin
      for (int c = 0; c < 8; c++) begin
        bus(1, 32'h0, 32'(m * 2 + c * 8));
        tin[c / 2] <= c[0];
        // Long gaps let the two-stage synchronizer settle
        repeat (6) @(posedge clk_sys);
        base = pcnt;
        tin[c / 2] <= !c[0];
        repeat (6) @(posedge clk_sys);
        tin[c / 2] <= c[0];
        repeat (6) @(posedge clk_sys);
        exp_q.push_back(base + 1);
        exp_q.push_back({24'h0, tin});
        snap <= 2'h2;
        @(posedge clk_sys);
        snap <= 0;
      end
    end
    final_report;
  end
endmodule
